/* emb_block.sv */
// Embedded memory block: RAM, product-term macrocells and search mode.
`timescale 1ns/100ps
`default_nettype none
`include "emb_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module emb_block (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic                     ce_i,
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [7:0]               wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [31:0]              wb_dat_i,
	output logic [31:0]                   wb_dat_o,
	output logic                          wb_ack_o,
	input  wire emb_pkg::emb_ram_req_type ram_req_i,
	output logic [15:0]                   col_data_o,
	output logic                          col_oe_o,
	input  wire logic [31:0]              pt_in_i,
	output logic [15:0]                   mc_o,
	output logic [9:0]                    local_o,
	input  wire logic                     cam_wr_i,
	input  wire emb_pkg::emb_cam_wr_type  cam_wr_data_i,
	output logic                          cam_busy_o,
	input  wire logic                     search_i,
	input  wire logic [31:0]              key_i,
	output emb_pkg::emb_match_type        match_o
);

	emb_pkg::emb_state_type     s_reg;
	emb_pkg::emb_state_type     s_next;
	emb_pkg::emb_ram_req_type   rq;
	emb_pkg::emb_status_type    status;
	logic [15:0]                ram_mem [128];
	logic [31:0]                pt_true [32];
	logic [31:0]                pt_comp [32];
	logic [17:0]                pt_fb   [32];
	logic [31:0]                hits;
	logic [31:0]                term;
	logic [15:0]                mc_comb;
	logic [15:0]                rd_row;
	logic [15:0]                rd_val;
	logic                       ram_wr;
	logic [6:0]                 wr_row;
	logic [15:0]                wr_word;
	logic                       wb_wr;
	logic                       data_we;
	logic                       dc_we;

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] wb_merge(input logic [31:0] old,
			input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction : wb_merge

	// Shape codes above four fall back to the 2048x1 layout.
	function automatic logic [2:0] shp(input logic [2:0] s);
		return (s > 3'd4) ? 3'd4 : s;
	endfunction : shp

	function automatic logic [15:0] wmask(input logic [2:0] s);
		int w;
		w = 16 >> shp(s);
		return 16'((32'd1 << w) - 32'd1);
	endfunction : wmask

	function automatic logic [3:0] lane_off(input logic [10:0] a,
			input logic [2:0] s);
		int lane;
		lane = int'(a) & ((1 << shp(s)) - 1);
		return 4'(lane * (16 >> shp(s)));
	endfunction : lane_off

	function automatic logic [6:0] row_of(input logic [10:0] a,
			input logic [2:0] s);
		return 7'(a >> shp(s));
	endfunction : row_of

	function automatic logic page_hit(input emb_pkg::emb_ctrl_type c,
			input logic [12:0] a);
		return !c.page_en || (a[12:11] == c.page_id);
	endfunction : page_hit

	////////////////////////////////////////////////////////////////////////
	// input registers
	always_comb begin
		rq       = ram_req_i;
		rq.din   = s_reg.ctrl.in_reg[0] ? s_reg.ram_q.din   : ram_req_i.din;
		rq.waddr = s_reg.ctrl.in_reg[1] ? s_reg.ram_q.waddr : ram_req_i.waddr;
		rq.raddr = s_reg.ctrl.in_reg[2] ? s_reg.ram_q.raddr : ram_req_i.raddr;
		rq.we    = s_reg.ctrl.in_reg[3] ? s_reg.ram_q.we    : ram_req_i.we;
		rq.re    = s_reg.ctrl.in_reg[4] ? s_reg.ram_q.re    : ram_req_i.re;
	end

	assign rd_row  = ram_mem[row_of(rq.raddr[10:0], s_reg.ctrl.shape)];
	assign rd_val  = (rd_row >> lane_off(rq.raddr[10:0], s_reg.ctrl.shape))
		& wmask(s_reg.ctrl.shape);
	assign wr_row  = row_of(rq.waddr[10:0], s_reg.ctrl.shape);
	assign wr_word = (ram_mem[wr_row] & ~(wmask(s_reg.ctrl.shape)
		<< lane_off(rq.waddr[10:0], s_reg.ctrl.shape)))
		| ((rq.din & wmask(s_reg.ctrl.shape))
		<< lane_off(rq.waddr[10:0], s_reg.ctrl.shape));

	assign ram_wr = (s_reg.ctrl.mode == emb_pkg::EMB_MODE_RAM) && rq.we
		&& page_hit(s_reg.ctrl, rq.waddr);

	always_ff @(posedge clk_i) begin
		if (ce_i && ram_wr) begin
			ram_mem[wr_row] <= wr_word;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// term inputs and feedback
	always_comb begin
		for (int t = 0; t < 32; t++) begin
			term[t] = ((pt_true[t] | pt_comp[t]) != 32'h0000_0000
				|| pt_fb[t] != 18'h0_0000)
				&& ((pt_in_i & pt_true[t]) == pt_true[t])
				&& ((~pt_in_i & pt_comp[t]) == pt_comp[t])
				&& ((s_reg.local_out[8:0] & pt_fb[t][8:0]) == pt_fb[t][8:0])
				&& ((~s_reg.local_out[8:0] & pt_fb[t][17:9])
					== pt_fb[t][17:9]);
		end
		for (int m = 0; m < 16; m++) begin
			mc_comb[m] = term[2*m] | term[2*m+1];
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign wb_wr   = wb_cyc_i && wb_stb_i && wb_we_i && s_reg.ack;
	assign data_we = (s_reg.cw_state == emb_pkg::CW_DATA);
	assign dc_we   = (s_reg.cw_state == emb_pkg::CW_DC);

	always_ff @(posedge clk_i) begin
		if (ce_i && wb_wr) begin
			unique case (wb_adr_i)
				`EMB_PT_TRUE_OFS: pt_true[s_reg.pt_sel] <=
					wb_merge(pt_true[s_reg.pt_sel], wb_dat_i, wb_sel_i);
				`EMB_PT_COMP_OFS: pt_comp[s_reg.pt_sel] <=
					wb_merge(pt_comp[s_reg.pt_sel], wb_dat_i, wb_sel_i);
				`EMB_PT_FB_OFS: begin
					pt_fb[s_reg.pt_sel] <= {
						wb_dat_i[`EMB_FB_COMP_LSB +: `EMB_FB_W],
						wb_dat_i[`EMB_FB_TRUE_LSB +: `EMB_FB_W]};
				end
				default: begin
				end
			endcase
		end
	end

	emb_cam_core i_emb_cam_core (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.data_we_i (data_we),
		.dc_we_i   (dc_we),
		.wr_i      (s_reg.cw),
		.key_i     (s_reg.key),
		.hits_o    (hits)
	);

	always_comb begin
		status           = '0;
		status.mode      = s_reg.ctrl.mode;
		status.cw_busy   = s_reg.cam_busy;
		status.boot_pend = s_reg.boot_pend;
		status.sr_busy   = (s_reg.sr_state != emb_pkg::SR_IDLE);
		status.found     = s_reg.match.found;
		status.addr      = s_reg.match.addr;
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_next       = s_reg;
		s_next.ram_q = ram_req_i;

		// Ack one cycle after the request; writes land on the ack edge.
		s_next.ack   = wb_cyc_i && wb_stb_i && !s_reg.ack;
		s_next.rdata = 32'h0000_0000;
		if (wb_cyc_i && wb_stb_i && !wb_we_i && !s_reg.ack) begin
			unique case (wb_adr_i)
				`EMB_CTRL_OFS:     s_next.rdata = 32'(s_reg.ctrl);
				`EMB_MC_CFG_OFS:   s_next.rdata = 32'(s_reg.mc_cfg);
				`EMB_PT_SEL_OFS:   s_next.rdata = 32'(s_reg.pt_sel);
				`EMB_PT_TRUE_OFS:  s_next.rdata = pt_true[s_reg.pt_sel];
				`EMB_PT_COMP_OFS:  s_next.rdata = pt_comp[s_reg.pt_sel];
				`EMB_PT_FB_OFS:    s_next.rdata = {7'h00,
					pt_fb[s_reg.pt_sel][17:9], 7'h00, pt_fb[s_reg.pt_sel][8:0]};
				`EMB_CAM_IDX_OFS:  s_next.rdata = 32'(s_reg.boot.addr);
				`EMB_CAM_DATA_OFS: s_next.rdata = s_reg.boot.data;
				`EMB_CAM_DC_OFS:   s_next.rdata = s_reg.boot.dc;
				`EMB_STATUS_OFS:   s_next.rdata = 32'(status);
				`EMB_HITS_OFS:     s_next.rdata = s_reg.hits;
				default:           s_next.rdata = 32'h0000_0000;
			endcase
		end
		if (wb_wr) begin
			unique case (wb_adr_i)
				`EMB_CTRL_OFS: s_next.ctrl = emb_pkg::emb_ctrl_type'(
					15'(wb_merge(32'(s_reg.ctrl), wb_dat_i,
					wb_sel_i)));
				`EMB_MC_CFG_OFS: s_next.mc_cfg =
					16'(wb_merge(32'(s_reg.mc_cfg), wb_dat_i, wb_sel_i));
				`EMB_PT_SEL_OFS: s_next.pt_sel =
					wb_sel_i[0] ? wb_dat_i[4:0] : s_reg.pt_sel;
				`EMB_CAM_IDX_OFS: s_next.boot.addr =
					wb_sel_i[0] ? wb_dat_i[4:0] : s_reg.boot.addr;
				`EMB_CAM_DATA_OFS: s_next.boot.data =
					wb_merge(s_reg.boot.data, wb_dat_i, wb_sel_i);
				`EMB_CAM_DC_OFS: s_next.boot.dc =
					wb_merge(s_reg.boot.dc, wb_dat_i, wb_sel_i);
				default: begin
				end
			endcase
		end

		// Synchronous read; an extra stage is added when selected.
		if (rq.re) begin
			s_next.ram_dout = rd_val;
		end
		s_next.col_data = s_reg.ctrl.out_reg ? s_reg.ram_dout
			: (rq.re ? rd_val : s_reg.ram_dout);
		s_next.col_oe = (s_reg.ctrl.mode == emb_pkg::EMB_MODE_RAM)
			&& page_hit(s_reg.ctrl, rq.raddr);

		s_next.mc_q   = mc_comb;
		s_next.mc_out = (s_reg.mc_cfg & s_reg.mc_q) | (~s_reg.mc_cfg & mc_comb);
		// ten local outputs, the last one doubling line eight
		unique case (s_reg.ctrl.mode)
			emb_pkg::EMB_MODE_PTERM: s_next.local_out =
				{s_next.mc_out[8], s_next.mc_out[8:0]};
			emb_pkg::EMB_MODE_CAM: s_next.local_out =
				{s_reg.match.found, s_reg.match.found, 3'h0, s_reg.match.addr};
			default: s_next.local_out =
				{s_next.col_data[8], s_next.col_data[8:0]};
		endcase

		// bus preload request stays pending until served
		if (wb_wr && wb_adr_i == `EMB_CAM_GO_OFS) begin
			s_next.boot_pend = 1'b1;
		end

		unique case (s_reg.cw_state)
			emb_pkg::CW_IDLE: begin
				if (cam_wr_i) begin
					s_next.cw       = cam_wr_data_i;
					s_next.cw_state = emb_pkg::CW_DATA;
				end else if (s_reg.boot_pend) begin
					s_next.cw        = s_reg.boot;
					s_next.boot_pend = wb_wr
						&& wb_adr_i == `EMB_CAM_GO_OFS;
					s_next.cw_state  = emb_pkg::CW_DATA;
				end
			end
			emb_pkg::CW_DATA: begin
				s_next.cw_state = (s_reg.cw.dc != 32'h0000_0000)
					? emb_pkg::CW_DC : emb_pkg::CW_IDLE;
			end
			emb_pkg::CW_DC: begin
				s_next.cw_state = emb_pkg::CW_IDLE;
			end
		endcase
		s_next.cam_busy = (s_next.cw_state != emb_pkg::CW_IDLE);

		s_next.match.valid       = 1'b0;
		s_next.match.lines_valid = 1'b0;
		unique case (s_reg.sr_state)
			emb_pkg::SR_IDLE: begin
				if (search_i && s_reg.ctrl.mode == emb_pkg::EMB_MODE_CAM) begin
					s_next.key      = key_i;
					s_next.sr_state = emb_pkg::SR_LO;
				end
			end
			emb_pkg::SR_LO: begin
				s_next.hits        = hits;
				s_next.match.found = (hits != 32'h0000_0000);
				s_next.match.addr  = 5'h00;
				for (int w = 31; w >= 0; w--) begin
					if (hits[w]) begin
						s_next.match.addr = 5'(w);
					end
				end
				s_next.match.valid = s_reg.ctrl.encoded;
				if (!s_reg.ctrl.encoded) begin
					s_next.match.lines       = hits[15:0];
					s_next.match.lines_hi    = 1'b0;
					s_next.match.lines_valid = 1'b1;
					s_next.sr_state          = emb_pkg::SR_HI;
				end else begin
					s_next.sr_state = emb_pkg::SR_IDLE;
				end
			end
			emb_pkg::SR_HI: begin
				s_next.match.lines       = s_reg.hits[31:16];
				s_next.match.lines_hi    = 1'b1;
				s_next.match.lines_valid = 1'b1;
				s_next.sr_state          = emb_pkg::SR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg          <= '0;
			s_reg.ctrl     <= `EMB_CTRL_RST;
			s_reg.mc_cfg   <= `EMB_MC_CFG_RST;
			s_reg.cw_state <= emb_pkg::CW_IDLE;
			s_reg.sr_state <= emb_pkg::SR_IDLE;
		end else if (ce_i) begin
			s_reg <= s_next;
		end
	end

	assign wb_dat_o   = s_reg.rdata;
	assign wb_ack_o   = s_reg.ack;
	assign col_data_o = s_reg.col_data;
	assign col_oe_o   = s_reg.col_oe;
	assign mc_o       = s_reg.mc_out;
	assign local_o    = s_reg.local_out;
	assign cam_busy_o = s_reg.cam_busy;
	assign match_o    = s_reg.match;

endmodule : emb_block

`default_nettype wire

/* emb_block_asserts.sv */
// Port checker of the embedded memory block.
`timescale 1ns/100ps
`default_nettype none

module emb_block_asserts (
	input wire logic			clk_i,
	input wire logic			rst_i,
	input wire logic			ce_i,
	input wire logic			wb_cyc_i,
	input wire logic			wb_stb_i,
	input wire logic			wb_ack_o,
	input wire logic			cam_wr_i,
	input wire emb_pkg::emb_cam_wr_type	cam_wr_data_i,
	input wire logic			cam_busy_o,
	input wire logic			search_i,
	input wire emb_pkg::emb_match_type	match_o,
	input wire logic [9:0]			local_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence take_plain;
		ce_i && cam_wr_i && !cam_busy_o && cam_wr_data_i.dc == 32'h0000_0000;
	endsequence
	sequence take_mask;
		ce_i && cam_wr_i && !cam_busy_o && cam_wr_data_i.dc != 32'h0000_0000;
	endsequence
	sequence lines_lo;
		match_o.lines_valid && !match_o.lines_hi;
	endsequence

	////////////////////////////////////////////////////////////////////////////
	ack_answer_a: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	busy_plain_a: assert property (
		take_plain |=> cam_busy_o ##1 !cam_busy_o)
		else $error("plain word write not two cycles");
	busy_mask_a: assert property (
		take_mask |=> cam_busy_o [*2] ##1 !cam_busy_o)
		else $error("masked word write not three cycles");
	enc_latency_a: assert property (
		match_o.valid |-> $past(search_i, 2))
		else $error("encoded result at wrong time");
	enc_pulse_a: assert property (
		match_o.valid |=> !match_o.valid)
		else $error("encoded result longer than one cycle");
	lines_pair_a: assert property (
		lines_lo |=> match_o.lines_valid && match_o.lines_hi)
		else $error("upper match lines missing");
	lines_latency_a: assert property (
		lines_lo |-> $past(search_i, 2))
		else $error("lower match lines at wrong time");
	lines_order_a: assert property (
		match_o.lines_valid && match_o.lines_hi |->
		$past(match_o.lines_valid) && !$past(match_o.lines_hi))
		else $error("upper match lines not after lower");
	dup_out_a: assert property (local_o[9] == local_o[8])
		else $error("shared local output differs");
endmodule : emb_block_asserts

bind emb_block emb_block_asserts i_emb_block_asserts (.clk_i(clk_i),
	.rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .cam_wr_i(cam_wr_i), .cam_wr_data_i(cam_wr_data_i),
	.cam_busy_o(cam_busy_o), .search_i(search_i), .match_o(match_o),
	.local_o(local_o));
`default_nettype wire

/* emb_block_tb.sv */
// Self-checking bench of the embedded memory block.
`timescale 1ns/100ps
`default_nettype none
`include "emb_regs.svh"

module emb_block_tb;
	logic				clk_i = 1'b0;
	logic				rst_i = 1'b1;
	logic				ce_i = 1'b1;
	logic				wb_cyc_i = 1'b0;
	logic				wb_stb_i = 1'b0;
	logic				wb_we_i = 1'b0;
	logic [7:0]			wb_adr_i = 8'h00;
	logic [3:0]			wb_sel_i = 4'hF;
	logic [31:0]			wb_dat_i = 32'h0000_0000;
	logic [31:0]			wb_dat_o;
	logic				wb_ack_o;
	emb_pkg::emb_ram_req_type	ram_req_i = '0;
	logic [15:0]			col_data_o;
	logic				col_oe_o;
	logic [31:0]			pt_in_i = 32'h0000_0000;
	logic [15:0]			mc_o;
	logic [9:0]			local_o;
	logic				cam_wr_i;
	emb_pkg::emb_cam_wr_type	cam_wr_data_i;
	logic				cam_busy_o;
	logic				search_i = 1'b0;
	logic [31:0]			key_i = 32'h0000_0000;
	emb_pkg::emb_match_type		match_o;
	logic				go = 1'b0;
	emb_pkg::emb_cam_wr_type	word = '0;
	logic				done;
	logic [1:0]			re_pipe = 2'b00;
	logic				oreg = 1'b0;
	logic				pt_chk = 1'b0;
	logic [31:0]			pt_p1;
	logic [31:0]			pt_p2;
	logic [15:0]			mc_e;
	int				errors = 0;
	int				total_checks = 0;
	int				cycles = 0;
	logic [31:0]			wd [32];
	logic [31:0]			dm [32];
	logic [31:0]			rdq [$];
	logic [32:0]			ramq [$];
	logic [5:0]			encq [$];
	logic [16:0]			lnq [$];
	logic [32:0]			rx;
	logic [16:0]			lx;
	logic [5:0]			mx;
	logic [12:0]			a;
	logic [15:0]			d;
	logic [15:0]			m;
	logic [31:0]			k;

	emb_block i_emb_block (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ram_req_i(ram_req_i),
		.col_data_o(col_data_o), .col_oe_o(col_oe_o), .pt_in_i(pt_in_i),
		.mc_o(mc_o), .local_o(local_o), .cam_wr_i(cam_wr_i),
		.cam_wr_data_i(cam_wr_data_i), .cam_busy_o(cam_busy_o),
		.search_i(search_i), .key_i(key_i), .match_o(match_o));
	emb_user_model i_emb_user_model (.clk_i(clk_i), .rst_i(rst_i),
		.go_i(go), .word_i(word), .busy_i(cam_busy_o),
		.cam_wr_o(cam_wr_i), .wr_o(cam_wr_data_i), .done_o(done));

	always #5 clk_i = ~clk_i;

	task automatic print_verdict;
		if (errors == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask : check

	// Each term is programmed to follow one input, so a cell is an OR pair.
	function automatic logic [15:0] mc_exp(input logic [31:0] p);
		for (int i = 0; i < 16; i++)
			mc_exp[i] = p[2*i] | p[2*i+1];
	endfunction : mc_exp

	task automatic wb(input logic we, input logic [7:0] ad,
			input logic [31:0] dt);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= ad;
		wb_dat_i <= dt;
		do
			@(posedge clk_i);
		while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	task automatic rd(input logic [7:0] ad, input logic [31:0] e);
		rdq.push_back(e);
		wb(1'b0, ad, 32'h0000_0000);
	endtask : rd

	task automatic ram_op(input logic we, input logic re,
			input logic [12:0] ad, input logic [15:0] dt,
			input logic [32:0] e);
		if (re)
			ramq.push_back(e);
		ram_req_i <= '{we: we, re: re, waddr: ad, raddr: ad, din: dt};
		@(posedge clk_i);
	endtask : ram_op

	task automatic cam_put(input logic [4:0] ad, input logic [31:0] dt,
			input logic [31:0] mk);
		int n;
		n = 0;
		wd[ad] = dt;
		dm[ad] = mk;
		word <= '{addr: ad, data: dt, dc: mk};
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		do begin
			@(posedge clk_i);
			n++;
		end while (done !== 1'b1 && n < 20);
		check(n < 20, 1'b1);
	endtask : cam_put

	// The expected hits come from the bench's own copy of words and masks.
	task automatic find(input logic [31:0] kk, input logic enc);
		logic [31:0] hit;
		logic [5:0] e;
		e = 6'h00;
		for (int i = 31; i >= 0; i--) begin
			hit[i] = ((wd[i] ^ kk) & ~dm[i]) == 32'h0000_0000;
			if (hit[i])
				e = {1'b1, 5'(i)};
		end
		if (enc) begin
			encq.push_back(e);
		end else begin
			lnq.push_back({1'b0, hit[15:0]});
			lnq.push_back({1'b1, hit[31:16]});
		end
		key_i <= kk;
		search_i <= 1'b1;
		@(posedge clk_i);
		search_i <= 1'b0;
		repeat (5) @(posedge clk_i);
	endtask : find

	////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			errors++;
			print_verdict();
		end
		pt_in_i <= $urandom;
		pt_p2 <= pt_p1;
		pt_p1 <= pt_in_i;
		if (pt_chk) begin
			mc_e = mc_exp(pt_p2);
			check(mc_o, mc_e);
			check(local_o, {mc_e[8], mc_e[8:0]});
		end
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
			check(wb_dat_o, rdq.pop_front());
		if ((oreg ? re_pipe[1] : re_pipe[0]) === 1'b1) begin
			rx = ramq.pop_front();
			check(col_oe_o, rx[32]);
			check(col_data_o & rx[31:16], rx[15:0]);
		end
		re_pipe <= {re_pipe[0], ram_req_i.re};
		if (match_o.valid === 1'b1) begin
			mx = encq.pop_front();
			check(match_o.found, mx[5]);
			if (mx[5])
				check(match_o.addr, mx[4:0]);
		end
		if (match_o.lines_valid === 1'b1) begin
			lx = lnq.pop_front();
			check({match_o.lines_hi, match_o.lines}, lx);
		end
	end

	initial begin
		void'($urandom(32'h7955_d568));
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(`EMB_CTRL_OFS, 32'h0000_0000);
		rd(`EMB_MC_CFG_OFS, 32'h0000_0000);
		rd(8'h40, 32'h0000_0000);
		for (int s = 0; s < 5; s++) begin
			wb(1'b1, `EMB_CTRL_OFS, {19'h0, 3'(s), 9'h000, s[0]});
			oreg <= s[0];
			a = 13'($urandom) & ((13'h1 << (s + 7)) - 13'h1);
			d = 16'($urandom);
			m = 16'((32'h1 << (16 >> s)) - 32'h1);
			ram_op(1'b1, 1'b0, a, d, 33'h0);
			ram_op(1'b0, 1'b1, a, d, {1'b1, m, d & m});
			ram_op(1'b0, 1'b0, a, d, 33'h0);
		end
		// A write to another page must be dropped and leave no driver on.
		wb(1'b1, `EMB_CTRL_OFS, 32'h0000_1180);
		a = {2'd2, 11'($urandom)};
		d = 16'($urandom);
		ram_op(1'b1, 1'b0, a, d, 33'h0);
		ram_op(1'b1, 1'b0, a ^ 13'h1800, ~d, 33'h0);
		// A write while the clock enable is low must not land.
		ce_i <= 1'b0;
		ram_op(1'b1, 1'b0, a, ~d, 33'h0);
		ce_i <= 1'b1;
		ram_op(1'b0, 1'b1, a ^ 13'h1800, d, 33'h0);
		ram_op(1'b0, 1'b1, a, d, {1'b1, 16'h0001, 15'h0, d[0]});
		ram_op(1'b0, 1'b0, a, d, 33'h0);
		for (int t = 0; t < 32; t++) begin
			wb(1'b1, `EMB_PT_SEL_OFS, 32'(t));
			wb(1'b1, `EMB_PT_TRUE_OFS, 32'h0000_0001 << t);
			wb(1'b1, `EMB_PT_COMP_OFS, 32'h0000_0000);
			wb(1'b1, `EMB_PT_FB_OFS, 32'h0000_0000);
		end
		wb(1'b1, `EMB_MC_CFG_OFS, 32'h0000_FFFF);
		wb(1'b1, `EMB_CTRL_OFS, 32'h0000_2000);
		pt_chk <= 1'b1;
		repeat (8) @(posedge clk_i);
		pt_chk <= 1'b0;
		wb(1'b1, `EMB_CTRL_OFS, 32'h0000_4200);
		rd(`EMB_CTRL_OFS, 32'h0000_4200);
		for (int i = 0; i < 32; i++)
			cam_put(5'(i), {27'($urandom), 5'(i)}, 32'h0000_0000);
		find(wd[12], 1'b1);
		rd(`EMB_STATUS_OFS, 32'h0000_042C);
		rd(`EMB_HITS_OFS, 32'h0000_1000);
		find(wd[12] ^ 32'h8000_0000, 1'b1);
		cam_put(5'd20, {wd[12][31:5], 5'd20}, 32'h0000_001F);
		find({wd[12][31:5], 5'd7}, 1'b1);
		k = $urandom;
		wb(1'b1, `EMB_CAM_IDX_OFS, 32'h0000_001F);
		wb(1'b1, `EMB_CAM_DATA_OFS, k);
		wb(1'b1, `EMB_CAM_DC_OFS, 32'h0000_0000);
		wb(1'b1, `EMB_CAM_GO_OFS, 32'h0000_0001);
		repeat (10) @(posedge clk_i);
		wd[31] = k;
		find(k, 1'b1);
		repeat (8) begin
			k = wd[$urandom_range(31)];
			find(k, 1'b1);
		end
		wb(1'b1, `EMB_CTRL_OFS, 32'h0000_4000);
		find(wd[12], 1'b0);
		find(k, 1'b0);
		check(rdq.size() + ramq.size() + encq.size() + lnq.size(), 0);
		print_verdict();
	end
endmodule : emb_block_tb
`default_nettype wire

/* emb_cam_core.sv */
// Search array: 32 words of 32 bits with per-bit don't-care masks.
`timescale 1ns/100ps
`default_nettype none

module emb_cam_core (
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	input  wire logic                    ce_i,
	input  wire logic                    data_we_i,
	input  wire logic                    dc_we_i,
	input  wire emb_pkg::emb_cam_wr_type wr_i,
	input  wire logic [31:0]             key_i,
	output logic [31:0]                  hits_o
);

	emb_pkg::emb_cam_state_type s_reg;
	emb_pkg::emb_cam_state_type s_next;
	logic [31:0]                data_mem [32];
	logic [31:0]                dc_mem   [32];

	always_comb begin
		s_next = s_reg;
		if (data_we_i) begin
			s_next.valid[wr_i.addr] = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
		end else if (ce_i) begin
			s_reg <= s_next;
		end
	end

	// The data cycle clears the mask so a plain word needs no third cycle.
	always_ff @(posedge clk_i) begin
		if (ce_i && data_we_i) begin
			data_mem[wr_i.addr] <= wr_i.data;
			dc_mem[wr_i.addr]   <= 32'h0000_0000;
		end else if (ce_i && dc_we_i) begin
			dc_mem[wr_i.addr] <= wr_i.dc;
		end
	end

	always_comb begin
		for (int w = 0; w < 32; w++) begin
			hits_o[w] = s_reg.valid[w] &&
				(((data_mem[w] ^ key_i) & ~dc_mem[w]) == 32'h0000_0000);
		end
	end

endmodule : emb_cam_core

`default_nettype wire

/* emb_pkg.sv */
// Types shared by the embedded memory block and its search array.
package emb_pkg;

	typedef enum logic [1:0] {
		EMB_MODE_RAM   = 2'h0,
		EMB_MODE_PTERM = 2'h1,
		EMB_MODE_CAM   = 2'h2,
		EMB_MODE_RSVD  = 2'h3
	} emb_mode_type;

	typedef enum logic [2:0] {
		CW_IDLE = 3'b001,
		CW_DATA = 3'b010,
		CW_DC   = 3'b100
	} emb_cw_state_type;

	typedef enum logic [2:0] {
		SR_IDLE = 3'b001,
		SR_LO   = 3'b010,
		SR_HI   = 3'b100
	} emb_sr_state_type;

	// Bits 0..4 of in_reg select input registers: din, waddr, raddr, we, re.
	typedef struct packed {
		emb_mode_type mode;
		logic [2:0]   shape;
		logic         encoded;
		logic         page_en;
		logic [1:0]   page_id;
		logic [4:0]   in_reg;
		logic         out_reg;
	} emb_ctrl_type;

	typedef struct packed {
		logic        we;
		logic        re;
		logic [12:0] waddr;
		logic [12:0] raddr;
		logic [15:0] din;
	} emb_ram_req_type;

	typedef struct packed {
		logic [4:0]  addr;
		logic [31:0] data;
		logic [31:0] dc;
	} emb_cam_wr_type;

	typedef struct packed {
		logic        valid;
		logic        found;
		logic [4:0]  addr;
		logic        lines_valid;
		logic        lines_hi;
		logic [15:0] lines;
	} emb_match_type;

	typedef struct packed {
		emb_mode_type mode;
		logic         cw_busy;
		logic         boot_pend;
		logic         sr_busy;
		logic         found;
		logic [4:0]   addr;
	} emb_status_type;

	typedef struct packed {
		logic [31:0] valid;
	} emb_cam_state_type;

	typedef struct packed {
		logic              ack;
		logic [31:0]       rdata;
		emb_ctrl_type      ctrl;
		logic [15:0]       mc_cfg;
		logic [4:0]        pt_sel;
		emb_ram_req_type   ram_q;
		logic [15:0]       ram_dout;
		logic [15:0]       col_data;
		logic              col_oe;
		logic [15:0]       mc_q;
		logic [15:0]       mc_out;
		logic [9:0]        local_out;
		emb_cw_state_type  cw_state;
		emb_cam_wr_type    cw;
		logic              cam_busy;
		emb_cam_wr_type    boot;
		logic              boot_pend;
		emb_sr_state_type  sr_state;
		logic [31:0]       key;
		logic [31:0]       hits;
		emb_match_type     match;
	} emb_state_type;

endpackage : emb_pkg

/* emb_regs.svh */
// Register offsets, field positions and reset values of the memory block.
`ifndef EMB_REGS_SVH
`define EMB_REGS_SVH

`define EMB_ADR_W        8
`define EMB_CTRL_OFS     8'h00
`define EMB_MC_CFG_OFS   8'h04
`define EMB_PT_SEL_OFS   8'h08
`define EMB_PT_TRUE_OFS  8'h0C
`define EMB_PT_COMP_OFS  8'h10
`define EMB_PT_FB_OFS    8'h14
`define EMB_CAM_IDX_OFS  8'h18
`define EMB_CAM_DATA_OFS 8'h1C
`define EMB_CAM_DC_OFS   8'h20
`define EMB_CAM_GO_OFS   8'h24
`define EMB_STATUS_OFS   8'h28
`define EMB_HITS_OFS     8'h2C

`define EMB_CTRL_RST     15'h0000
`define EMB_MC_CFG_RST   16'h0000
`define EMB_FB_TRUE_LSB  0
`define EMB_FB_COMP_LSB  16
`define EMB_FB_W         9

`endif

/* emb_user_model.sv */
// User logic that writes words into the search array.
`timescale 1ns/100ps
`default_nettype none

module emb_user_model (
	input wire logic			clk_i,
	input wire logic			rst_i,
	input wire logic			go_i,
	input wire emb_pkg::emb_cam_wr_type	word_i,
	input wire logic			busy_i,
	output var logic			cam_wr_o,
	output var emb_pkg::emb_cam_wr_type	wr_o,
	output var logic			done_o
);
	logic	wait_reg;

	// A released word bus shows the inverse so stale data cannot pass.
	always_ff @(posedge clk_i) begin
		done_o <= 1'b0;
		if (rst_i) begin
			cam_wr_o <= 1'b0;
			wr_o <= '1;
			wait_reg <= 1'b0;
		end else if (go_i) begin
			cam_wr_o <= 1'b1;
			wr_o <= word_i;
		end else if (cam_wr_o && !busy_i) begin
			cam_wr_o <= 1'b0;
			wr_o <= ~wr_o;
			wait_reg <= 1'b1;
		end else if (wait_reg && !busy_i) begin
			wait_reg <= 1'b0;
			done_o <= 1'b1;
		end
	end
endmodule : emb_user_model
`default_nettype wire
